// >>> logic/sfs_defs.svh
`ifndef SFS_DEFS_SVH
`define SFS_DEFS_SVH

// Opcodes
`define SFS_OP_WSR        8'h01
`define SFS_OP_WREN       8'h06
`define SFS_OP_ID         8'h9F
`define SFS_OP_LEGACY_ID  8'h15
`define SFS_OP_DPD        8'hB9
`define SFS_OP_RESUME     8'hAB

// Data byte field positions of the protection write
`define SFS_LOCK_POS      7
`define SFS_PROT_POS      2

// Frame counting
`define SFS_BIT_LAST      3'h7
`define SFS_BIT_ZERO      3'h0
`define SFS_BIT_ONE       3'h1
`define SFS_BYTE_ZERO     3'h0
`define SFS_BYTE_ONE      3'h1
`define SFS_BYTE_SAT      3'h7
`define SFS_WSR_BYTES     3'h2

// Answer lengths in bytes after the opcode
`define SFS_ID_BYTES      3'h4
`define SFS_LEGACY_BYTES  3'h2

// Extended information length of the standard ID read
`define SFS_EXT_LEN       8'h00

`endif

// >>> logic/sfs_pkg.sv
`default_nettype none

package sfs_pkg;

    // Link side, rising edge of the serial clock
    typedef struct packed {
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic [2:0] byte_cnt;
        logic [7:0] opcode;
        logic [7:0] data;
        logic       tog;
        logic       dpd_s1;
        logic       dpd_s2;
    } sfs_link_t;

    // Link side, falling edge of the serial clock
    typedef struct packed {
        logic so;
        logic oe;
    } sfs_out_t;

    // System clock side
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_d;
        logic tog_s1;
        logic tog_s2;
        logic tog_seen;
        logic wp_s1;
        logic wp_s2;
        logic protect_lock_bit;
        logic bp0;
        logic write_enable_latch;
        logic dpd;
        logic standby;
    } sfs_sys_t;

endpackage : sfs_pkg

`default_nettype wire

// >>> logic/sfs_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfs_defs.svh"

module sfs_core #(
    parameter logic [7:0] MFR_ID  = 8'hA5,  // Arbitrary
    parameter logic [7:0] DEV_ID1 = 8'h3C,  // Arbitrary
    parameter logic [7:0] DEV_ID2 = 8'h5E   // Arbitrary
) (
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    input  wire logic sck_i,
    input  wire logic cs_n_i,
    input  wire logic si_i,
    input  wire logic wp_n_i,
    input  wire logic busy_i,
    output var  logic so_o,
    output var  logic so_oe_o,
    output var  logic protect_lock_bit_o,
    output var  logic array_protect_bit_o,
    output var  logic write_enable_latch_o,
    output var  logic deep_power_down_o,
    output var  logic standby_o
);
    import sfs_pkg::*;

    sfs_link_t lk_r;
    sfs_link_t lk_nxt;
    sfs_out_t  ou_r;
    sfs_out_t  ou_nxt;
    sfs_sys_t  sy_r;
    sfs_sys_t  sy_nxt;
    logic      in_frame_r;
    logic      frame_rst;
    logic      act;
    logic      op_full;
    logic      aligned;
    logic      wp_on;
    logic      wsr_ok;

    function automatic logic [7:0] id_byte(input logic [7:0] op, input logic [1:0] idx);
        logic [7:0] b;
        b = `SFS_EXT_LEN;
        case (idx)
            2'h0:    b = MFR_ID;
            2'h1:    b = DEV_ID1;
            2'h2:    b = (op == `SFS_OP_ID) ? DEV_ID2 : `SFS_EXT_LEN;
            default: b = `SFS_EXT_LEN;
        endcase
        return b;
    endfunction : id_byte

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: frame marker cleared by deselect, the frame's own signal
    assign frame_rst = sys_rst_i | cs_n_i;

    always_ff @(posedge sck_i or posedge frame_rst) begin
        if (frame_rst) begin
            in_frame_r <= 1'b0;
        end else begin
            in_frame_r <= 1'b1;
        end
    end

    // Captured bytes survive deselect so the system side can read them
    always_comb begin
        logic [2:0] bit_now;
        logic [2:0] byte_now;
        logic [7:0] sh;
        bit_now        = in_frame_r ? lk_r.bit_cnt : `SFS_BIT_ZERO;
        byte_now       = in_frame_r ? lk_r.byte_cnt : `SFS_BYTE_ZERO;
        sh             = {lk_r.shift[6:0], si_i};
        lk_nxt         = lk_r;
        lk_nxt.dpd_s1  = sy_r.dpd;
        lk_nxt.dpd_s2  = lk_r.dpd_s1;
        lk_nxt.shift   = sh;
        lk_nxt.bit_cnt = bit_now + `SFS_BIT_ONE;
        lk_nxt.byte_cnt = byte_now;
        if (!in_frame_r) begin
            lk_nxt.tog = ~lk_r.tog;
        end
        if (bit_now == `SFS_BIT_LAST) begin
            if (byte_now != `SFS_BYTE_SAT) begin
                lk_nxt.byte_cnt = byte_now + `SFS_BYTE_ONE;
            end
            if (byte_now == `SFS_BYTE_ZERO) begin
                lk_nxt.opcode = sh;
            end
            // Later bytes never overwrite the data byte
            if (byte_now == `SFS_BYTE_ONE) begin
                lk_nxt.data = sh;
            end
        end
    end

    always_ff @(posedge sck_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lk_r <= '0;
        end else begin
            lk_r <= lk_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial output, driven on the falling edge
    always_comb begin
        logic [2:0] idx;
        logic [7:0] b;
        logic       show;
        idx    = lk_r.byte_cnt - `SFS_BYTE_ONE;
        b      = id_byte(lk_r.opcode, idx[1:0]);
        show   = in_frame_r && !lk_r.dpd_s2 && (lk_r.byte_cnt != `SFS_BYTE_ZERO) &&
                 (((lk_r.opcode == `SFS_OP_ID) && (idx < `SFS_ID_BYTES)) ||
                  ((lk_r.opcode == `SFS_OP_LEGACY_ID) && (idx < `SFS_LEGACY_BYTES)));
        ou_nxt.oe = show;
        ou_nxt.so = show & b[`SFS_BIT_LAST - lk_r.bit_cnt];
    end

    // Deselect clears the driver at once, mid-byte included
    always_ff @(negedge sck_i or posedge frame_rst) begin
        if (frame_rst) begin
            ou_r <= '0;
        end else begin
            ou_r <= ou_nxt;
        end
    end

    assign so_o    = ou_r.so;
    assign so_oe_o = ou_r.oe;

    ////////////////////////////////////////////////////////////////////////////
    // System domain: commit on synchronised deselect
    // Link bytes are static once deselect is seen here: no clock edges remain
    assign act     = sy_r.cs_s2 & ~sy_r.cs_d & (sy_r.tog_s2 != sy_r.tog_seen);
    assign op_full = lk_r.byte_cnt != `SFS_BYTE_ZERO;
    assign aligned = lk_r.bit_cnt == `SFS_BIT_ZERO;
    assign wp_on   = ~sy_r.wp_s2;
    assign wsr_ok  = (lk_r.byte_cnt >= `SFS_WSR_BYTES) && aligned && sy_r.write_enable_latch;

    always_comb begin
        sy_nxt        = sy_r;
        sy_nxt.cs_s1  = cs_n_i;
        sy_nxt.cs_s2  = sy_r.cs_s1;
        sy_nxt.cs_d   = sy_r.cs_s2;
        sy_nxt.tog_s1 = lk_r.tog;
        sy_nxt.tog_s2 = sy_r.tog_s1;
        sy_nxt.wp_s1  = wp_n_i;
        sy_nxt.wp_s2  = sy_r.wp_s1;
        if (sy_r.cs_s2 & ~sy_r.cs_d) begin
            sy_nxt.tog_seen = sy_r.tog_s2;
        end
        if (act) begin
            if (sy_r.dpd) begin
                if (op_full && aligned && (lk_r.opcode == `SFS_OP_RESUME)) begin
                    sy_nxt.dpd = 1'b0;
                end
            end else begin
                case (lk_r.opcode)
                    `SFS_OP_WSR: begin
                        if (op_full) begin
                            sy_nxt.write_enable_latch = 1'b0;
                            // Locked and pin asserted: lock and protect bits may not change
                            if (wsr_ok && !(wp_on && sy_r.protect_lock_bit)) begin
                                sy_nxt.protect_lock_bit = lk_r.data[`SFS_LOCK_POS];
                                sy_nxt.bp0 = lk_r.data[`SFS_PROT_POS];
                            end
                        end
                    end
                    `SFS_OP_WREN: begin
                        if (op_full && aligned) begin
                            sy_nxt.write_enable_latch = 1'b1;
                        end
                    end
                    `SFS_OP_DPD: begin
                        if (op_full && aligned && !busy_i) begin
                            sy_nxt.dpd = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        sy_nxt.standby = sy_r.cs_s2 & ~sy_nxt.dpd & ~busy_i;
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // Chip-select synchronisers start at the idle deselect level: no false edge after reset
            sy_r <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1, default: 1'b0};
        end else begin
            sy_r <= sy_nxt;
        end
    end

    assign protect_lock_bit_o   = sy_r.protect_lock_bit;
    assign array_protect_bit_o  = sy_r.bp0;
    assign write_enable_latch_o = sy_r.write_enable_latch;
    assign deep_power_down_o    = sy_r.dpd;
    assign standby_o            = sy_r.standby;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_wsr_clears_wel: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        act && !sy_r.dpd && op_full && (lk_r.opcode == `SFS_OP_WSR) |=> !sy_r.write_enable_latch)
        else $error("write enable not cleared after protection write");

    a_wsr_commit_bits: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        act && !sy_r.dpd && (lk_r.opcode == `SFS_OP_WSR) && wsr_ok && !wp_on
        |=> (sy_r.protect_lock_bit == $past(lk_r.data[`SFS_LOCK_POS])) && (sy_r.bp0 == $past(lk_r.data[`SFS_PROT_POS])))
        else $error("protection bits not taken from data byte");

    a_wsr_abort_keep: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        act && (lk_r.opcode == `SFS_OP_WSR) && !aligned |=> $stable(sy_r.protect_lock_bit) && $stable(sy_r.bp0))
        else $error("aborted protection write changed bits");

    a_wp_lock_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        sy_r.protect_lock_bit && wp_on && act |=> sy_r.protect_lock_bit && $stable(sy_r.bp0))
        else $error("locked protection changed while pin asserted");

    a_dpd_entry_ok: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        act && !sy_r.dpd && op_full && aligned && (lk_r.opcode == `SFS_OP_DPD) && !busy_i
        |=> sy_r.dpd ##1 !sy_r.standby)
        else $error("power-down not entered");

    a_dpd_abort_stay: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        act && !sy_r.dpd && (lk_r.opcode == `SFS_OP_DPD) && (!aligned || busy_i) |=> !sy_r.dpd)
        else $error("power-down entered on bad frame");

    a_dpd_ignores_all: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        sy_r.dpd && act && (lk_r.opcode != `SFS_OP_RESUME)
        |=> sy_r.dpd && $stable(sy_r.write_enable_latch) && $stable(sy_r.protect_lock_bit) && $stable(sy_r.bp0))
        else $error("command acted on during power-down");

    a_resume_exit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        sy_r.dpd && act && op_full && aligned && (lk_r.opcode == `SFS_OP_RESUME) |=> !sy_r.dpd)
        else $error("resume did not leave power-down");

    a_so_off_deselect: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        sy_r.cs_s2 && sy_r.cs_d |-> !so_oe_o)
        else $error("output driven while deselected");

    a_wp_clear_refused: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        act && !sy_r.dpd && (lk_r.opcode == `SFS_OP_WSR) && wp_on && sy_r.protect_lock_bit
        |=> sy_r.protect_lock_bit && !sy_r.write_enable_latch)
        else $error("lock cleared while pin asserted");

    a_legacy_len_bound: assert property (@(negedge sck_i) disable iff (sys_rst_i)
        (lk_r.opcode == `SFS_OP_LEGACY_ID) && (lk_r.byte_cnt > `SFS_LEGACY_BYTES) |-> ##0 !ou_nxt.oe)
        else $error("legacy identification output past last byte");

    a_id_len_bound: assert property (@(negedge sck_i) disable iff (sys_rst_i)
        (lk_r.byte_cnt > `SFS_ID_BYTES) |-> ##0 !ou_nxt.oe)
        else $error("identification output past last byte");

endmodule : sfs_core

`default_nettype wire

// >>> sim/sfs_host.sv
`timescale 1ns/1ps
`default_nettype none

module sfs_host (
    output var  logic sck_o,
    output var  logic cs_n_o,
    output var  logic si_o,
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    initial begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    // Mode 0 frame, 32 ns period; clock idles low between frames
    task automatic xfer(input logic [39:0] tx, input int nbits, output logic [31:0] rx, output int oe_cnt);
        rx = '0;
        oe_cnt = 0;
        #3;
        cs_n_o = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            si_o = tx[39-i];
            #16 sck_o = 1'b1;
            if (so_oe_i === 1'b1) begin
                oe_cnt++;
                rx = {rx[30:0], so_i};
            end
            #16 sck_o = 1'b0;
        end
        #16 cs_n_o = 1'b1;
        // Released line must not keep the last bit
        si_o = ~si_o;
        // Deselect long enough for the commit to land
        #100;
    endtask : xfer
endmodule : sfs_host

`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        clk_sys_i;
    logic        sys_rst_i;
    logic        wp_n_i;
    logic        busy_i;
    wire logic   sck, cs_n, si, so, so_oe, lock, prot, write_enable_latch, dpd, stby;
    int          bad_count = 0;
    int          total_checks = 0;
    int          seed = 28257;
    int          oc;
    logic [31:0] rx;
    logic [7:0]  d;
    logic [31:0] r;
    logic [1:0]  e;
    logic [8:0]  corner [4] = '{9'h180, 9'h004, 9'h000, 9'h100};

    sfs_core u_sfs_core (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
        .wp_n_i(wp_n_i), .busy_i(busy_i), .so_o(so), .so_oe_o(so_oe), .protect_lock_bit_o(lock),
        .array_protect_bit_o(prot), .write_enable_latch_o(write_enable_latch), .deep_power_down_o(dpd), .standby_o(stby));
    sfs_host u_sfs_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // {lock, protect, wel, power-down, standby} at a quiet falling edge
    task automatic st(input logic [4:0] exp);
        @(negedge clk_sys_i);
        chk({27'h0, lock, prot, write_enable_latch, dpd, stby}, {27'h0, exp});
    endtask : st

    task automatic tx(input logic [39:0] v, input int n);
        u_sfs_host.xfer(v, n, rx, oc);
    endtask : tx

    // Commit outcome: old lock plus asserted pin freezes lock and protect
    function automatic logic [1:0] exp_pr(input logic l, input logic p, input logic [7:0] dd, input logic wpn);
        if (!wpn && l) return {l, p};
        return {dd[7], dd[2]};
    endfunction : exp_pr

    initial begin
        sys_rst_i = 1'b1;
        wp_n_i = 1'b1;
        busy_i = 1'b0;
        repeat (5) @(posedge clk_sys_i);
        @(negedge clk_sys_i) sys_rst_i = 1'b0;
        repeat (5) @(negedge clk_sys_i);
        st(5'b00001);
        tx({8'h9F, 32'h0}, 48);
        chk(rx, 32'hA53C_5E00);
        chk(oc, 32);
        tx({8'h15, 32'h0}, 32);
        chk({rx[15:0], oc[15:0]}, 32'hA53C_0010);
        tx({8'h9F, 32'h0}, 13);
        chk({so_oe, rx[4:0]}, 6'h14);
        tx({8'h15, 32'h0}, 11);
        chk({so_oe, rx[2:0]}, 4'h5);
        tx({8'h01, 8'h84, 24'h0}, 16);
        st(5'b00001);
        for (int k = 0; k < 10; k++) begin
            r = $random(seed);
            @(negedge clk_sys_i);
            wp_n_i = (k < 4) ? corner[k][8] : r[8];
            d = (k < 4) ? corner[k][7:0] : r[7:0];
            e = exp_pr(lock, prot, d, wp_n_i);
            tx({8'h06, 32'h0}, 8);
            st({lock, prot, 3'b101});
            tx({8'h01, d, r[31:16], 8'h0}, (k > 5) ? 32 : 16);
            st({e, 3'b001});
        end
        tx({8'h06, 32'h0}, 8);
        e = {lock, prot};
        tx({8'h01, ~d, 24'h0}, 12);
        st({e, 3'b001});
        @(negedge clk_sys_i) busy_i = 1'b1;
        tx({8'hB9, 32'h0}, 8);
        st({e, 3'b000});
        @(negedge clk_sys_i) busy_i = 1'b0;
        tx({8'hB9, 32'h0}, 12);
        st({e, 3'b001});
        tx({8'hB9, 32'hFFFF_FFFF}, 16);
        st({e, 3'b010});
        tx({8'h9F, 32'h0}, 40);
        chk(oc, 0);
        tx({8'h06, 32'h0}, 8);
        st({e, 3'b010});
        tx({8'hAB, 32'h0}, 12);
        st({e, 3'b010});
        tx({8'hAB, 32'h0}, 8);
        st({e, 3'b001});
        test_done();
    end

    initial begin
        #500_000;
        bad_count++;
        test_done();
    end
endmodule : tb

`default_nettype wire
